// ---- hdl/fso_pkg.sv ----
// fso_pkg: shared constants, types and helpers for the frequency setpoint block.
// assumes frequencies in units of 0.01 Hz and percents as whole numbers.
`default_nettype none
package fso_pkg;

	localparam int FREQ_W = 16;
	localparam int PCT_W  = 7;
	localparam int ADDR_W = 8;

	typedef logic [FREQ_W-1:0] fso_freq_t;
	typedef logic [PCT_W-1:0]  fso_pct_t;
	typedef logic [1:0]        fso_code_t;

	// 400.00 Hz in 0.01 Hz units
	localparam fso_freq_t FREQ_MAX      = 16'h9C40;
	localparam fso_freq_t FREQ_RST      = 16'h0000;
	localparam fso_pct_t  PCT_FULL      = 7'h64;
	localparam fso_pct_t  START_PCT_RST = 7'h00;
	localparam fso_pct_t  END_PCT_RST   = 7'h64;

	localparam fso_code_t DIR_ADD   = 2'h0;
	localparam fso_code_t DIR_SUB   = 2'h1;
	localparam fso_code_t LOW_START = 2'h0;
	localparam fso_code_t LOW_ZERO  = 2'h1;
	localparam fso_code_t DIR_RST   = DIR_ADD;
	localparam fso_code_t LOW_RST   = LOW_ZERO;

	localparam logic [2:0] SRC_POT = 3'h1;

	localparam logic [ADDR_W-1:0] ADDR_OFS_FREQ  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_OFS_DIR   = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_POT_FS    = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_POT_FE    = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_POT_SP    = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_POT_EP    = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_POT_LOW   = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h1C;
	localparam logic [ADDR_W-1:0] ADDR_FREQ_OUT  = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_POT_FREQ  = 8'h24;

	localparam int STAT_ACT_BIT  = 0;
	localparam int STAT_BUSY_BIT = 1;

	// saturating narrowing used for writes and for the offset sum
	function automatic fso_freq_t fso_sat_freq(input logic [31:0] v);
		return (v > 32'(FREQ_MAX)) ? FREQ_MAX : v[FREQ_W-1:0];
	endfunction

	function automatic fso_pct_t fso_sat_pct(input logic [31:0] v);
		return (v > 32'(PCT_FULL)) ? PCT_FULL : v[PCT_W-1:0];
	endfunction

endpackage
`default_nettype wire

// ---- hdl/fso_calc_if.sv ----
// fso_calc_if: request and answer of one potentiometer mapping calculation.
// assumes the requester holds its operands steady while req is high.
`timescale 1ns/100ps
`default_nettype none
interface fso_calc_if #(parameter int XW = 17);
	logic              req;
	logic [XW-1:0]     x;
	logic [XW-1:0]     xs;
	logic [XW-1:0]     xe;
	fso_pkg::fso_freq_t fs;
	fso_pkg::fso_freq_t fe;
	logic              low_zero;
	logic              done;
	fso_pkg::fso_freq_t result;

	modport calc_m (output req, x, xs, xe, fs, fe, low_zero, input done, result);
	modport calc_s (input req, x, xs, xe, fs, fe, low_zero, output done, result);
endinterface
`default_nettype wire

// ---- hdl/fso_interp.sv ----
// fso_interp: maps a scaled potentiometer reading onto the frequency range.
// assumes operands stable while req is high; one bit of quotient per cycle.
`timescale 1ns/100ps
`default_nettype none
module fso_interp #(
	parameter int XW = 17
) (
	input wire logic    clk_sys_i,
	input wire logic    rst_b_i,
	input wire logic    ce_i,
	fso_calc_if.calc_s  bus
);
	import fso_pkg::*;

	localparam int NW = FREQ_W + XW;
	localparam int CW = $clog2(NW + 1);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DIV  = 3'b010,
		ST_DONE = 3'b100
	} fso_st_t;

	fso_st_t       st_q;
	logic [NW-1:0] quo_q;
	logic [XW:0]   rem_q;
	logic [XW-1:0] den_q;
	logic [CW-1:0] cnt_q;
	logic          neg_q;
	fso_freq_t     fs_q;
	fso_freq_t     res_q;
	fso_freq_t     mag;
	logic [XW:0]   rtmp;
	logic          ge;
	logic [NW-1:0] qnext;
	logic          below;
	logic          above;

	assign below = bus.x < bus.xs;
	assign above = bus.x >= bus.xe;
	assign mag   = (bus.fe >= bus.fs) ? bus.fe - bus.fs : bus.fs - bus.fe;
	assign rtmp  = {rem_q[XW-1:0], quo_q[NW-1]};
	assign ge    = rtmp >= {1'b0, den_q};
	assign qnext = {quo_q[NW-2:0], ge};

	assign bus.done   = (st_q == ST_DONE);
	assign bus.result = res_q;

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
			st_q <= ST_IDLE;
		else if (ce_i)
			case (st_q)
				ST_IDLE: if (bus.req) st_q <= (below || above) ? ST_DONE : ST_DIV;
				ST_DIV:  if (cnt_q == CW'(1)) st_q <= ST_DONE;
				ST_DONE: st_q <= ST_IDLE;
				default: st_q <= ST_IDLE;
			endcase
	end

	// restoring divide: frequency span times distance past the start point over the span
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			quo_q <= '0;
			rem_q <= '0;
			den_q <= '0;
			cnt_q <= '0;
			neg_q <= 1'b0;
			fs_q  <= FREQ_RST;
			res_q <= FREQ_RST;
		end
		else if (ce_i)
			case (st_q)
				ST_IDLE: if (bus.req)
				begin
					fs_q  <= bus.fs;
					neg_q <= bus.fe < bus.fs;
					den_q <= bus.xe - bus.xs;
					rem_q <= '0;
					cnt_q <= CW'(NW);
					quo_q <= NW'(mag) * NW'(bus.x - bus.xs);
					res_q <= below ? (bus.low_zero ? FREQ_RST : bus.fs) : bus.fe;
				end
				ST_DIV:
				begin
					rem_q <= ge ? rtmp - {1'b0, den_q} : rtmp;
					quo_q <= qnext;
					cnt_q <= cnt_q - CW'(1);
					if (cnt_q == CW'(1))
						res_q <= neg_q ? fs_q - qnext[FREQ_W-1:0] : fs_q + qnext[FREQ_W-1:0];
				end
				default: ;
			endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	a_low_end_out: assert property (
		(st_q == ST_IDLE && bus.req && ce_i && below) |=>
		(st_q == ST_DONE && res_q == ($past(bus.low_zero) ? FREQ_RST : $past(bus.fs))))
		else $error("low end output wrong");
	a_end_point: assert property (
		(st_q == ST_IDLE && bus.req && ce_i && !below && above) |=>
		(st_q == ST_DONE && res_q == $past(bus.fe)))
		else $error("end point output wrong");
	a_interp_dir: assert property (
		(st_q == ST_DIV && cnt_q == CW'(1) && ce_i) |=>
		(neg_q ? res_q <= fs_q : res_q >= fs_q) && st_q == ST_DONE)
		else $error("interpolation left its range");
	c_interp_done: cover property (st_q == ST_DIV && cnt_q == CW'(1) && ce_i);

endmodule // fso_interp
`default_nettype wire

// ---- hdl/fso_top.sv ----
// fso_top: frequency setpoint offset and potentiometer scaling with APB registers.
// assumes synchronous inputs and frequencies in 0.01 Hz units; APB waits only on ce_i.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module fso_top #(
	parameter int POT_W = 10
) (
	input  wire logic                  clk_sys_i,
	input  wire logic                  rst_b_i,
	input  wire logic                  ce_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [7:0]            paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic [POT_W-1:0]      pot_i,
	input  wire fso_pkg::fso_freq_t    cmd_freq_i,
	input  wire logic [2:0]            cmd_src_sel_i,
	input  wire logic                  run_i,
	input  wire logic                  add_term_i,
	output fso_pkg::fso_freq_t         freq_cmd_o,
	output fso_pkg::fso_freq_t         pot_freq_o,
	output logic                       offset_active_o
);
	import fso_pkg::*;

	localparam int XW = POT_W + PCT_W;
	localparam logic [XW-1:0] POT_FS = XW'((1 << POT_W) - 1);

	////////////////////////////////////////////////////////////////////////////////
	// setting registers

	fso_freq_t offset_frequency_value_q;
	fso_code_t offset_direction_select_q;
	fso_freq_t pot_start_frequency_q;
	fso_freq_t pot_end_frequency_q;
	fso_pct_t  pot_start_percent_q;
	fso_pct_t  pot_end_percent_q;
	fso_code_t pot_low_end_select_q;

	fso_freq_t pot_freq_q;
	fso_freq_t freq_q;
	logic      act_q;
	logic      busy_q;

	logic [31:0] prdata_q;
	logic        err_q;
	logic        taken_q;

	logic      setup;
	logic      cap;
	logic      acc;
	logic      wr_en;
	logic      mapped;
	logic      read_only;
	logic      run_locked;
	fso_freq_t base_freq;
	fso_freq_t sum_freq;
	fso_freq_t diff_freq;
	logic [31:0] rd_mux;

	fso_calc_if #(.XW(XW)) calc_bus ();

	////////////////////////////////////////////////////////////////////////////////
	// apb decode

	assign setup    = psel_i && !penable_i;
	assign acc      = psel_i && penable_i && ce_i;
	assign cap      = ce_i && psel_i && (!penable_i || !taken_q);
	assign wr_en    = acc && taken_q && pwrite_i && !err_q;
	assign pready_o = ce_i && taken_q;
	assign prdata_o = prdata_q;
	assign pslverr_o = err_q;

	always_comb
	begin
		mapped = 1'b1;
		read_only = 1'b0;
		case (paddr_i)
			ADDR_OFS_FREQ, ADDR_OFS_DIR, ADDR_POT_FS, ADDR_POT_FE,
			ADDR_POT_SP, ADDR_POT_EP, ADDR_POT_LOW: read_only = 1'b0;
			ADDR_STATUS, ADDR_FREQ_OUT, ADDR_POT_FREQ: read_only = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// only the offset value may change while the drive runs
	assign run_locked = run_i && (paddr_i != ADDR_OFS_FREQ);

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (paddr_i)
			ADDR_OFS_FREQ: rd_mux = 32'(offset_frequency_value_q);
			ADDR_OFS_DIR:  rd_mux = 32'(offset_direction_select_q);
			ADDR_POT_FS:   rd_mux = 32'(pot_start_frequency_q);
			ADDR_POT_FE:   rd_mux = 32'(pot_end_frequency_q);
			ADDR_POT_SP:   rd_mux = 32'(pot_start_percent_q);
			ADDR_POT_EP:   rd_mux = 32'(pot_end_percent_q);
			ADDR_POT_LOW:  rd_mux = 32'(pot_low_end_select_q);
			ADDR_STATUS:
			begin
				rd_mux[STAT_ACT_BIT]  = act_q;
				rd_mux[STAT_BUSY_BIT] = busy_q;
			end
			ADDR_FREQ_OUT: rd_mux = 32'(freq_q);
			ADDR_POT_FREQ: rd_mux = 32'(pot_freq_q);
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	// read data and the error answer are settled in setup, so the access is zero-wait
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			prdata_q <= 32'h0000_0000;
			err_q    <= 1'b0;
		end
		else if (cap)
		begin
			prdata_q <= pwrite_i ? 32'h0000_0000 : rd_mux;
			err_q    <= !mapped || (pwrite_i && (read_only || run_locked));
		end
	end

	// a setup cycle lost to a low ce_i is caught up in access, costing one wait state
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
			taken_q <= 1'b0;
		else if (ce_i)
		begin
			if (acc && taken_q)
				taken_q <= 1'b0;
			else if (cap)
				taken_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// offset settings; out-of-range offset values saturate instead of being refused, the direction keeps only bit 0

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			offset_frequency_value_q  <= FREQ_RST;
			offset_direction_select_q <= DIR_RST;
		end
		else if (wr_en)
			case (paddr_i)
				ADDR_OFS_FREQ: offset_frequency_value_q <= fso_sat_freq(pwdata_i);
				ADDR_OFS_DIR:  offset_direction_select_q <= {1'b0, pwdata_i[0]};
				default: ;
			endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// potentiometer mapping settings

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			pot_start_frequency_q <= FREQ_RST;
			pot_end_frequency_q   <= FREQ_RST;
			pot_start_percent_q   <= START_PCT_RST;
			pot_end_percent_q     <= END_PCT_RST;
			pot_low_end_select_q  <= LOW_RST;
		end
		else if (wr_en)
			case (paddr_i)
				ADDR_POT_FS:  pot_start_frequency_q <= fso_sat_freq(pwdata_i);
				ADDR_POT_FE:  pot_end_frequency_q   <= fso_sat_freq(pwdata_i);
				ADDR_POT_SP:  pot_start_percent_q   <= fso_sat_pct(pwdata_i);
				ADDR_POT_EP:  pot_end_percent_q     <= fso_sat_pct(pwdata_i);
				ADDR_POT_LOW: pot_low_end_select_q  <= {1'b0, pwdata_i[0]};
				default: ;
			endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// potentiometer mapping; recomputed back to back, so it lags the pot by one pass

	assign calc_bus.req      = 1'b1;
	assign calc_bus.x        = XW'(pot_i) * XW'(PCT_FULL);
	assign calc_bus.xs       = XW'(pot_start_percent_q) * POT_FS;
	assign calc_bus.xe       = XW'(pot_end_percent_q) * POT_FS;
	assign calc_bus.fs       = pot_start_frequency_q;
	assign calc_bus.fe       = pot_end_frequency_q;
	assign calc_bus.low_zero = (pot_low_end_select_q == LOW_ZERO);

	fso_interp #(.XW(XW)) u_interp (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.ce_i      (ce_i),
		.bus       (calc_bus.calc_s)
	);

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			pot_freq_q <= FREQ_RST;
			busy_q     <= 1'b0;
		end
		else if (ce_i)
		begin
			busy_q <= !calc_bus.done;
			if (calc_bus.done)
				pot_freq_q <= calc_bus.result;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// offset stage; the sum is held at 400 Hz so an offset cannot overrun the range

	assign base_freq = (cmd_src_sel_i == SRC_POT) ? pot_freq_q : cmd_freq_i;
	assign sum_freq  = fso_sat_freq(32'(base_freq) + 32'(offset_frequency_value_q));
	assign diff_freq = (base_freq >= offset_frequency_value_q) ?
		base_freq - offset_frequency_value_q : FREQ_RST;

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			freq_q <= FREQ_RST;
			act_q  <= 1'b0;
		end
		else if (ce_i)
		begin
			act_q <= add_term_i;
			if (!add_term_i)
				freq_q <= base_freq;
			else if (offset_direction_select_q == DIR_SUB)
				freq_q <= diff_freq;
			else
				freq_q <= sum_freq;
		end
	end

	assign freq_cmd_o      = freq_q;
	assign pot_freq_o      = pot_freq_q;
	assign offset_active_o = act_q;

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	a_offset_bypass: assert property (
		(ce_i && !add_term_i) |=> freq_q == $past(base_freq))
		else $error("command altered without offset terminal");
	a_offset_pot_src: assert property (
		(ce_i && add_term_i && cmd_src_sel_i == SRC_POT &&
		offset_direction_select_q == DIR_ADD) |=>
		freq_q == fso_sat_freq(32'($past(pot_freq_q)) + 32'($past(offset_frequency_value_q))))
		else $error("offset missing on pot source");
	a_offset_add: assert property (
		(ce_i && add_term_i && cmd_src_sel_i != SRC_POT &&
		offset_direction_select_q == DIR_ADD) |=>
		freq_q == fso_sat_freq(32'($past(cmd_freq_i)) + 32'($past(offset_frequency_value_q))))
		else $error("offset not added");
	a_offset_sub: assert property (
		(ce_i && add_term_i && offset_direction_select_q == DIR_SUB &&
		base_freq >= offset_frequency_value_q) |=>
		freq_q == $past(base_freq) - $past(offset_frequency_value_q))
		else $error("offset not subtracted");
	a_sub_clamp: assert property (
		(ce_i && add_term_i && offset_direction_select_q == DIR_SUB &&
		base_freq < offset_frequency_value_q) |=> freq_q == FREQ_RST)
		else $error("subtraction not clamped at zero");
	a_offset_range: assert property (
		offset_frequency_value_q <= FREQ_MAX)
		else $error("offset out of range");
	a_offset_runedit: assert property (
		(setup && ce_i && pwrite_i && paddr_i == ADDR_OFS_FREQ && run_i) ##1
		(acc && $stable(pwdata_i)) |=>
		offset_frequency_value_q == fso_sat_freq($past(pwdata_i)))
		else $error("offset not writable while running");
	a_pot_freqs: assert property (
		pot_start_frequency_q <= FREQ_MAX && pot_end_frequency_q <= FREQ_MAX)
		else $error("pot frequency out of range");
	a_pot_percents: assert property (
		pot_start_percent_q <= PCT_FULL && pot_end_percent_q <= PCT_FULL)
		else $error("pot percent out of range");
	a_reset_values: assert property (disable iff (1'b0)
		!rst_b_i |=> offset_frequency_value_q == FREQ_RST &&
		pot_low_end_select_q == LOW_ZERO && pot_end_percent_q == END_PCT_RST &&
		offset_direction_select_q == DIR_ADD)
		else $error("wrong reset values");

	c_sub_clamp: cover property (ce_i && add_term_i &&
		offset_direction_select_q == DIR_SUB && base_freq < offset_frequency_value_q);
	c_pot_offset: cover property (ce_i && add_term_i && cmd_src_sel_i == SRC_POT);
	c_apb_error: cover property (acc && err_q);
	c_run_edit: cover property (wr_en && run_i && paddr_i == ADDR_OFS_FREQ);

endmodule // fso_top
`default_nettype wire

// ---- testbench/fso_panel_model.sv ----
// fso_panel_model: operator panel potentiometer and offset-enable terminal.
// assumes the bench sets the wanted levels; outputs follow one edge later.
`timescale 1ns/100ps
`default_nettype none
module fso_panel_model #(
	parameter int POT_W = 10
) (
	input  wire logic             clk_sys_i,
	input  wire logic [POT_W-1:0] pot_level_i,
	input  wire logic             term_level_i,
	output logic      [POT_W-1:0] pot_o,
	output logic                  add_term_o
);
	// a real knob and a debounced terminal only ever change synchronously here
	always_ff @(posedge clk_sys_i)
	begin
		pot_o      <= pot_level_i;
		add_term_o <= term_level_i;
	end
endmodule // fso_panel_model
`default_nettype wire

// ---- testbench/fso_top_test.sv ----
// fso_top_test: register and command path checks of the setpoint block.
// assumes an APB slave that stretches access while ce_i is low, and the panel model.
`timescale 1ns/100ps
`default_nettype none
module fso_top_test;
	import fso_pkg::*;

	logic              clk_sys_i;
	logic              rst_b_i;
	logic              ce_i;
	logic              psel_i;
	logic              penable_i;
	logic              pwrite_i;
	logic [7:0]        paddr_i;
	logic [31:0]       pwdata_i;
	logic [31:0]       prdata_o;
	logic              pready_o;
	logic              pslverr_o;
	logic [9:0]        pot_i;
	logic [9:0]        pot_lvl;
	fso_freq_t         cmd_freq_i;
	logic [2:0]        cmd_src_sel_i;
	logic              run_i;
	logic              add_term_i;
	logic              term_lvl;
	fso_freq_t         freq_cmd_o;
	fso_freq_t         pot_freq_o;
	logic              offset_active_o;
	int                miscompares;
	int                check_count;
	int                cycles;
	logic [31:0]       rdat;
	logic              rerr;

	fso_top #(.POT_W(10)) dut (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .pot_i(pot_i), .cmd_freq_i(cmd_freq_i),
		.cmd_src_sel_i(cmd_src_sel_i), .run_i(run_i), .add_term_i(add_term_i),
		.freq_cmd_o(freq_cmd_o), .pot_freq_o(pot_freq_o),
		.offset_active_o(offset_active_o)
	);

	fso_panel_model #(.POT_W(10)) panel (
		.clk_sys_i(clk_sys_i), .pot_level_i(pot_lvl), .term_level_i(term_lvl),
		.pot_o(pot_i), .add_term_o(add_term_i)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	task automatic end_of_test();
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard: whole sequence needs under two thousand cycles
	always @(posedge clk_sys_i)
	begin
		cycles = cycles + 1;
		if (cycles >= 20000)
		begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %0t timeout", $time);
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp)
		begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic e);
		@(posedge clk_sys_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= wd;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		while (pready_o !== 1'b1)
			@(posedge clk_sys_i);
		rd = prdata_o;
		e  = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
		apb(1'b1, a, d, rdat, rerr);
		chk({31'h0, rerr}, {31'h0, exp_err});
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, rdat, rerr);
		chk(rdat, exp);
		chk({31'h0, rerr}, 32'h0);
	endtask

	task automatic cmd_chk(input logic [2:0] s, input int base, input logic t, input int exp);
		cmd_src_sel_i <= s;
		cmd_freq_i    <= base[15:0];
		term_lvl      <= t;
		repeat (4) @(posedge clk_sys_i);
		chk({16'h0, freq_cmd_o}, exp);
		chk({31'h0, offset_active_o}, {31'h0, t});
	endtask

	// reference mapping in 0.01 Hz; knob full scale is 1023 counts
	function automatic int pot_map(input int p, input int fs, input int fe, input int sp,
		input int ep, input int lz);
		int x;
		int xs;
		int xe;
		x  = p * 100;
		xs = sp * 1023;
		xe = ep * 1023;
		if (x < xs)
			return (lz != 0) ? 0 : fs;
		if (x >= xe)
			return fe;
		return fs + (fe - fs) * (x - xs) / (xe - xs);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0]  raddr [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	logic [31:0] rval  [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h64, 32'h1};
	logic [2:0]  srcs  [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
	int          pots  [7] = '{0, 204, 205, 512, 818, 819, 1023};

	initial
	begin
		miscompares = 0;
		check_count = 0;
		cycles      = 0;
		rst_b_i = 1'b0;
		ce_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		pot_lvl = 10'h000;
		term_lvl = 1'b0;
		cmd_freq_i = 16'h0000;
		cmd_src_sel_i = 3'h0;
		run_i = 1'b0;
		repeat (5) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 7; i++)
			rdc(raddr[i], rval[i]);
		wr(8'h00, 32'hFFFF, 1'b0);
		rdc(8'h00, 32'h9C40);
		wr(8'h10, 32'hC8, 1'b0);
		rdc(8'h10, 32'h64);
		wr(8'h00, 32'h1F4, 1'b0);
		for (int i = 0; i < 5; i++)
		begin
			cmd_chk(srcs[i], 1000, 1'b0, 1000);
			cmd_chk(srcs[i], 1000, 1'b1, 1500);
		end
		wr(8'h04, 32'h1, 1'b0);
		cmd_chk(3'h0, 1000, 1'b1, 500);
		cmd_chk(3'h0, 300, 1'b1, 0);
		wr(8'h04, 32'h0, 1'b0);
		cmd_chk(3'h0, 39800, 1'b1, 40000);
		wr(8'h08, 32'd1000, 1'b0);
		wr(8'h0C, 32'd5000, 1'b0);
		wr(8'h10, 32'd20, 1'b0);
		wr(8'h14, 32'd80, 1'b0);
		for (int lz = 1; lz >= 0; lz--)
		begin
			wr(8'h18, lz, 1'b0);
			for (int i = 0; i < 7; i++)
			begin
				pot_lvl <= pots[i][9:0];
				// two full mapping passes of 35 cycles each, plus margin
				repeat (100) @(posedge clk_sys_i);
				chk({16'h0, pot_freq_o}, pot_map(pots[i], 1000, 5000, 20, 80, lz));
			end
		end
		pot_lvl <= 10'd512;
		repeat (100) @(posedge clk_sys_i);
		cmd_chk(3'h1, 0, 1'b1, pot_map(512, 1000, 5000, 20, 80, 0) + 500);
		run_i <= 1'b1;
		wr(8'h08, 32'd7, 1'b1);
		rdc(8'h08, 32'd1000);
		wr(8'h00, 32'd100, 1'b0);
		rdc(8'h00, 32'd100);
		cmd_chk(3'h1, 0, 1'b1, pot_map(512, 1000, 5000, 20, 80, 0) + 100);
		rdc(8'h20, pot_map(512, 1000, 5000, 20, 80, 0) + 100);
		rdc(8'h24, pot_map(512, 1000, 5000, 20, 80, 0));
		apb(1'b0, 8'h1C, 32'h0, rdat, rerr);
		chk({31'h0, rdat[STAT_ACT_BIT]}, 32'h1);
		wr(8'h20, 32'h0, 1'b1);
		apb(1'b0, 8'h40, 32'h0, rdat, rerr);
		chk({31'h0, rerr}, 32'h1);
		// a low clock enable freezes the command and stretches the bus access
		ce_i          <= 1'b0;
		cmd_src_sel_i <= 3'h0;
		repeat (4) @(posedge clk_sys_i);
		chk({16'h0, freq_cmd_o}, pot_map(512, 1000, 5000, 20, 80, 0) + 100);
		fork
			rdc(8'h24, pot_map(512, 1000, 5000, 20, 80, 0));
			begin
				repeat (3) @(posedge clk_sys_i);
				ce_i <= 1'b1;
			end
		join
		run_i <= 1'b0;
		end_of_test();
	end
endmodule // fso_top_test
`default_nettype wire
